// >>> rtl/udmah_defs.svh
`ifndef UDMAH_DEFS_SVH
`define UDMAH_DEFS_SVH

`define UDMAH_REF_CLK_NS 40
`define UDMAH_T_RP_NS 160
`define UDMAH_T_ACK_NS 20
`define UDMAH_T_ZAH_NS 20
`define UDMAH_T_MLI_NS 20
`define UDMAH_T_DVS_NS 70
`define UDMAH_T_RP_CYC 8'((`UDMAH_T_RP_NS + `UDMAH_REF_CLK_NS - 1) / `UDMAH_REF_CLK_NS)
`define UDMAH_T_ACK_CYC 8'((`UDMAH_T_ACK_NS + `UDMAH_REF_CLK_NS - 1) / `UDMAH_REF_CLK_NS)
`define UDMAH_T_ZAH_CYC 8'((`UDMAH_T_ZAH_NS + `UDMAH_REF_CLK_NS - 1) / `UDMAH_REF_CLK_NS)
`define UDMAH_T_MLI_CYC 8'((`UDMAH_T_MLI_NS + `UDMAH_REF_CLK_NS - 1) / `UDMAH_REF_CLK_NS)
`define UDMAH_T_DVS_CYC 8'((`UDMAH_T_DVS_NS + `UDMAH_REF_CLK_NS - 1) / `UDMAH_REF_CLK_NS)
`define UDMAH_CRC_SEED 16'h4aba
`define UDMAH_CRC_POLY 16'h1021
`define UDMAH_WORD_RST 16'h0000
`define UDMAH_TIMER_RST 8'h00
`endif

// >>> rtl/udmah_pkg.sv
package udmah_pkg;
    typedef enum logic [3:0] {
        st_idle, st_arm, st_ack, st_xfer, st_pause, st_hterm, st_stop_wait,
        st_zah, st_crc, st_mli, st_release
    } udmah_state_t;
    typedef struct packed {
        logic dmack_n;
        logic stop;
        logic hdmardy_n;
        logic [15:0] dd_out;
        logic dd_oe_n;
    } udmah_pins_t;
    typedef struct packed {
        logic start;
        logic pause;
        logic resume;
        logic stop;
    } udmah_cmd_t;
    typedef struct packed {
        logic busy;
        logic paused;
        logic pio_allow;
        logic refused;
        logic dev_term;
    } udmah_stat_t;
    typedef struct packed {
        logic [15:0] data;
        logic valid;
        logic [15:0] count;
    } udmah_word_t;
    typedef struct packed {
        udmah_state_t state;
        logic [7:0] timer;
        udmah_pins_t pins;
        udmah_stat_t stat;
    } udmah_top_st_t;
endpackage

// >>> rtl/udmah_sync.sv
module udmah_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } udmah_sync_st_t;
    udmah_sync_st_t st_ff;
    udmah_sync_st_t nxt_st;

    always_comb
    begin
        nxt_st.s1 = d;
        nxt_st.s2 = st_ff.s1;
    end

    always_ff @(posedge clk)
    begin
        st_ff <= nxt_st;
    end

    assign q = st_ff.s2;
endmodule

// >>> rtl/udmah_link.sv
`include "udmah_defs.svh"
module udmah_link (
    input wire logic link_clk,
    input wire logic reset_n,
    input wire logic dstrobe,
    input wire logic [15:0] dd_in,
    input wire logic stop,
    input wire logic dmack_n,
    output udmah_pkg::udmah_word_t rx,
    output logic got_word,
    output logic [15:0] crc
);
    import udmah_pkg::*;
    typedef struct packed {
        udmah_word_t rx;
        logic strobe_d;
        logic got_word;
        logic [15:0] crc;
    } udmah_link_st_t;
    udmah_link_st_t st_ff;
    udmah_link_st_t nxt_st;
    logic [19:0] syn;

    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [15:0] w);
        logic [15:0] r;
        r = c;
        for (int i = 15; i >= 0; i--)
        begin
            r = {r[14:0], 1'b0} ^ (((r[15] ^ w[i]) == 1'b1) ? `UDMAH_CRC_POLY : 16'h0000);
        end
        return r;
    endfunction

    udmah_sync #(.W(20)) u_sync (
        .clk(link_clk),
        .d({reset_n, dstrobe, dd_in, stop, dmack_n}),
        .q(syn)
    );

    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.rx.valid = 1'b0;
        nxt_st.strobe_d = syn[18];
        if (!syn[19] || syn[0])
        begin
            nxt_st.crc = `UDMAH_CRC_SEED;
            nxt_st.got_word = 1'b0;
            nxt_st.rx.count = `UDMAH_WORD_RST;
        end
        else if ((syn[18] != st_ff.strobe_d) && !syn[1])
        begin
            nxt_st.rx.valid = 1'b1;
            nxt_st.rx.data = syn[17:2];
            nxt_st.rx.count = st_ff.rx.count + 16'h0001;
            nxt_st.got_word = 1'b1;
            nxt_st.crc = crc_step(st_ff.crc, syn[17:2]);
        end
    end

    always_ff @(posedge link_clk)
    begin
        if (!syn[19])
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign rx = st_ff.rx;
    assign got_word = st_ff.got_word;
    assign crc = st_ff.crc;
endmodule

// >>> rtl/udmah_host.sv
`include "udmah_defs.svh"
module udmah_host (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic link_clk,
    input udmah_pkg::udmah_cmd_t cmd,
    output udmah_pkg::udmah_stat_t stat,
    output udmah_pkg::udmah_word_t rx,
    input wire logic dmarq,
    input wire logic dstrobe,
    input wire logic [15:0] dd_in,
    output udmah_pkg::udmah_pins_t pins
);
    import udmah_pkg::*;
    udmah_top_st_t st_ff;
    udmah_top_st_t nxt_st;
    logic [18:0] syn;
    logic link_got_word;
    logic [15:0] link_crc;
    logic dmarq_s;
    logic strobe_s;
    logic got_word_s;
    logic [15:0] crc_s;

    ////////////////////////////////////////////////////////////////////////////
    // Link side capture and crossings
    udmah_link u_link (
        .link_clk(link_clk),
        .reset_n(reset_n),
        .dstrobe(dstrobe),
        .dd_in(dd_in),
        .stop(st_ff.pins.stop),
        .dmack_n(st_ff.pins.dmack_n),
        .rx(rx),
        .got_word(link_got_word),
        .crc(link_crc)
    );

    udmah_sync #(.W(19)) u_sync (
        .clk(ref_clk),
        .d({dmarq, dstrobe, link_got_word, link_crc}),
        .q(syn)
    );

    assign dmarq_s = syn[18];
    assign strobe_s = syn[17];
    assign got_word_s = syn[16];
    assign crc_s = syn[15:0];

    ////////////////////////////////////////////////////////////////////////////
    // Burst sequencer
    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.stat.refused = 1'b0;
        if (st_ff.timer != `UDMAH_TIMER_RST)
        begin
            nxt_st.timer = st_ff.timer - 8'h01;
        end
        case (st_ff.state)
            st_idle:
            begin
                nxt_st.pins.stop = 1'b1;
                nxt_st.pins.hdmardy_n = 1'b1;
                nxt_st.pins.dmack_n = 1'b1;
                nxt_st.pins.dd_oe_n = 1'b1;
                if (cmd.start && dmarq_s)
                begin
                    nxt_st.stat.dev_term = 1'b0;
                    nxt_st.timer = `UDMAH_T_ACK_CYC;
                    nxt_st.state = st_arm;
                end
            end
            st_arm:
            begin
                if (st_ff.timer == `UDMAH_TIMER_RST)
                begin
                    nxt_st.pins.dmack_n = 1'b0;
                    nxt_st.state = st_ack;
                end
            end
            st_ack:
            begin
                nxt_st.pins.stop = 1'b0;
                nxt_st.pins.hdmardy_n = 1'b0;
                nxt_st.state = st_xfer;
            end
            st_xfer:
            begin
                if (!dmarq_s)
                begin
                    nxt_st.pins.stop = 1'b1;
                    nxt_st.pins.hdmardy_n = 1'b1;
                    nxt_st.stat.dev_term = 1'b1;
                    nxt_st.timer = `UDMAH_T_ZAH_CYC;
                    nxt_st.state = st_zah;
                end
                else if ((cmd.stop || cmd.pause) && !got_word_s)
                begin
                    nxt_st.stat.refused = 1'b1;
                end
                else if (cmd.stop)
                begin
                    nxt_st.pins.hdmardy_n = 1'b1;
                    nxt_st.timer = `UDMAH_T_RP_CYC;
                    nxt_st.state = st_hterm;
                end
                else if (cmd.pause)
                begin
                    nxt_st.pins.hdmardy_n = 1'b1;
                    nxt_st.state = st_pause;
                end
                else if (cmd.resume)
                begin
                    nxt_st.stat.refused = 1'b1;
                end
            end
            st_pause:
            begin
                // Extra words still taken while paused
                if (!dmarq_s)
                begin
                    nxt_st.pins.stop = 1'b1;
                    nxt_st.stat.dev_term = 1'b1;
                    nxt_st.timer = `UDMAH_T_ZAH_CYC;
                    nxt_st.state = st_zah;
                end
                else if (cmd.resume)
                begin
                    nxt_st.pins.hdmardy_n = 1'b0;
                    nxt_st.state = st_xfer;
                end
                else if (cmd.stop)
                begin
                    nxt_st.timer = `UDMAH_T_RP_CYC;
                    nxt_st.state = st_hterm;
                end
                else if (cmd.pause)
                begin
                    nxt_st.stat.refused = 1'b1;
                end
            end
            st_hterm:
            begin
                if (!dmarq_s)
                begin
                    nxt_st.pins.stop = 1'b1;
                    nxt_st.stat.dev_term = 1'b1;
                    nxt_st.timer = `UDMAH_T_ZAH_CYC;
                    nxt_st.state = st_zah;
                end
                else if (st_ff.timer == `UDMAH_TIMER_RST)
                begin
                    nxt_st.pins.stop = 1'b1;
                    nxt_st.state = st_stop_wait;
                end
            end
            st_stop_wait:
            begin
                if (!dmarq_s)
                begin
                    nxt_st.timer = `UDMAH_T_ZAH_CYC;
                    nxt_st.state = st_zah;
                end
            end
            st_zah:
            begin
                // Drive the bus only after tZAH
                if (st_ff.timer == `UDMAH_TIMER_RST)
                begin
                    // CRC is the first value driven
                    nxt_st.pins.dd_out = crc_s;
                    nxt_st.pins.dd_oe_n = 1'b0;
                    nxt_st.timer = `UDMAH_T_DVS_CYC;
                    nxt_st.state = st_crc;
                end
            end
            st_crc:
            begin
                if (crc_s != st_ff.pins.dd_out)
                begin
                    nxt_st.pins.dd_out = crc_s;
                    nxt_st.timer = `UDMAH_T_DVS_CYC;
                end
                // Strobe high and DMARQ low, then tMLI
                else if ((st_ff.timer == `UDMAH_TIMER_RST) && strobe_s && !dmarq_s)
                begin
                    nxt_st.timer = `UDMAH_T_MLI_CYC;
                    nxt_st.state = st_mli;
                end
            end
            st_mli:
            begin
                if (st_ff.timer == `UDMAH_TIMER_RST)
                begin
                    nxt_st.pins.dmack_n = 1'b1;
                    nxt_st.timer = `UDMAH_T_ACK_CYC;
                    nxt_st.state = st_release;
                end
            end
            st_release:
            begin
                // Hold STOP and ready for tACK
                if (st_ff.timer == `UDMAH_TIMER_RST)
                begin
                    nxt_st.pins.dd_oe_n = 1'b1;
                    nxt_st.state = st_idle;
                end
            end
            default:
            begin
                nxt_st.state = st_idle;
            end
        endcase
        nxt_st.stat.busy = (nxt_st.state != st_idle);
        nxt_st.stat.paused = (nxt_st.state == st_pause);
        nxt_st.stat.pio_allow = (nxt_st.state == st_idle);
    end

    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            st_ff.state <= st_idle;
            st_ff.timer <= `UDMAH_TIMER_RST;
            st_ff.pins <= '{dmack_n: 1'b1, stop: 1'b1, hdmardy_n: 1'b1,
                            dd_out: `UDMAH_WORD_RST, dd_oe_n: 1'b1};
            st_ff.stat <= '{busy: 1'b0, paused: 1'b0, pio_allow: 1'b1,
                            refused: 1'b0, dev_term: 1'b0};
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign pins = st_ff.pins;
    assign stat = st_ff.stat;
endmodule

// >>> dv/udmah_host_properties.sv
module udmah_host_properties
    import udmah_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic link_clk,
    input udmah_pkg::udmah_cmd_t cmd,
    input udmah_pkg::udmah_stat_t stat,
    input udmah_pkg::udmah_word_t rx,
    input wire logic dmarq,
    input wire logic dstrobe,
    input wire logic [15:0] dd_in,
    input udmah_pkg::udmah_pins_t pins
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    sequence s_parked;
        pins.stop && pins.hdmardy_n;
    endsequence
    sequence s_crc_ready;
        !$past(pins.dd_oe_n, 3) && $past(dstrobe, 2) && !$past(dmarq, 2);
    endsequence
    ////////////////////////////////////////
    rdy_first_a: assert property ($rose(pins.stop) && dmarq |-> $past(pins.hdmardy_n, 4))
        else $error("stop raised early");
    drq_stop_a: assert property ($fell(dmarq) && !pins.dmack_n && !pins.stop |-> ##[1:5] s_parked)
        else $error("no stop after request drop");
    term_hold_a: assert property ($rose(pins.stop) |-> s_parked [*8])
        else $error("stop or ready released early");
    bus_turn_a: assert property ($fell(pins.dd_oe_n) |-> !dmarq && !$past(dmarq, 2))
        else $error("bus driven too soon");
    neg_ack_a: assert property ($rose(pins.dmack_n) |-> s_crc_ready)
        else $error("acknowledge dropped early");
    ack_hold_a: assert property ($rose(pins.dmack_n) |-> s_parked ##1 s_parked)
        else $error("stop or ready changed in hold");
    pio_block_a: assert property ($rose(pins.dmack_n) |-> !stat.pio_allow ##1 !stat.pio_allow ##1 stat.pio_allow)
        else $error("register access window wrong");
    crc_hold_a: assert property ($rose(pins.dmack_n) |-> pins.dd_out == $past(pins.dd_out, 4))
        else $error("check word not held before close");
    pause_rdy_a: assert property ($rose(stat.paused) |-> pins.hdmardy_n && !pins.stop)
        else $error("pause without ready negated");
endmodule
////////////////////////////////////////
bind udmah_host udmah_host_properties u_props (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .link_clk(link_clk),
    .cmd(cmd),
    .stat(stat),
    .rx(rx),
    .dmarq(dmarq),
    .dstrobe(dstrobe),
    .dd_in(dd_in),
    .pins(pins)
);

// >>> dv/udmah_drive_model.sv
module udmah_drive_model (
    input wire logic go,
    input wire logic hold,
    input wire logic [7:0] words,
    input wire logic dmack_n,
    input wire logic stop,
    input wire logic hdmardy_n,
    input wire logic [15:0] dd_w,
    output logic dmarq,
    output logic dstrobe,
    output logic [15:0] dd_dev,
    output logic crc_bad
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] crc;
    logic [7:0] sent;
    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [15:0] d);
        for (int b = 15; b >= 0; b--)
            c = (c[15] ^ d[b]) ? ((c << 1) ^ 16'h1021) : (c << 1);
        return c;
    endfunction
    ////////////////////////////////////////
    initial
    begin
        dmarq = 1'b0;
        dstrobe = 1'b1;
        dd_dev = 16'h0000;
        crc_bad = 1'b0;
        forever
        begin
            wait (go);
            dmarq = 1'b1;
            crc = 16'h4aba;
            sent = 8'h00;
            wait (!dmack_n && !stop && !hdmardy_n);
            while (!stop && (words == 8'h00 || sent != words))
            begin
                wait (!hold || sent == 8'h00);
                wait (!hdmardy_n || stop);
                if (!stop)
                begin
                    dd_dev = {sent, ~sent};
                    #120;
                    dstrobe = ~dstrobe;
                    crc = crc_step(crc, dd_dev);
                    sent++;
                    #60;
                end
            end
            #(stop ? 40 : 100);
            dmarq = 1'b0;
            #20 dd_dev = ~dd_dev;
            wait (stop);
            #100 dstrobe = 1'b1;
            @(posedge dmack_n);
            if (dd_w !== crc)
                crc_bad = 1'b1;
            #20 dstrobe = 1'b1;
            wait (!go);
        end
    end
endmodule

// >>> dv/udmah_host_tb.sv
module udmah_host_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import udmah_pkg::*;
    logic ref_clk;
    logic link_clk;
    logic reset_n;
    logic go;
    logic hold;
    logic dmarq;
    logic dstrobe;
    logic crc_bad;
    logic [7:0] words;
    logic [15:0] dd_dev;
    logic [15:0] dd_w;
    udmah_cmd_t cmd;
    udmah_stat_t stat;
    udmah_word_t rx;
    udmah_pins_t pins;
    int miscompares = 0;
    int checks_done = 0;
    int cycles = 0;
    logic [15:0] seen_count;
    logic [15:0] seen_data;
    assign dd_w = !pins.dd_oe_n ? pins.dd_out : dd_dev;
    udmah_host dut (
        .ref_clk(ref_clk), .reset_n(reset_n), .link_clk(link_clk), .cmd(cmd), .stat(stat),
        .rx(rx), .dmarq(dmarq), .dstrobe(dstrobe), .dd_in(dd_w), .pins(pins)
    );
    udmah_drive_model drive (
        .go(go), .hold(hold), .words(words), .dmack_n(pins.dmack_n), .stop(pins.stop),
        .hdmardy_n(pins.hdmardy_n), .dd_w(dd_w), .dmarq(dmarq), .dstrobe(dstrobe),
        .dd_dev(dd_dev), .crc_bad(crc_bad)
    );
    ////////////////////////////////////////
    initial
    begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    initial
    begin
        link_clk = 1'b0;
        #7;
        forever #24 link_clk = ~link_clk;
    end
    always @(posedge link_clk)
    begin
        if (rx.valid === 1'b1)
        begin
            seen_count <= rx.count;
            seen_data <= rx.data;
        end
    end
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            miscompares++;
            summarize();
        end
    end
    ////////////////////////////////////////
    task automatic summarize();
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic check(input logic got, input logic exp);
        checks_done++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[FAIL] %0t got %b expected %b", $time, got, exp);
        end
    endtask
    task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Command codes: 8 start, 4 pause, 2 resume, 1 stop
    task automatic issue(input logic [3:0] c, output logic refused);
        @(posedge ref_clk);
        #2 cmd = udmah_cmd_t'(c);
        @(posedge ref_clk);
        #2 cmd = '0;
        refused = stat.refused;
    endtask
    task automatic wait_idle();
        int n = 0;
        while (stat.busy !== 1'b0 && n < 500)
        begin
            @(posedge ref_clk);
            #2 n++;
        end
        check(stat.busy, 1'b0);
        go = 1'b0;
    endtask
    task automatic open_burst(input logic [7:0] n);
        logic r;
        @(posedge ref_clk);
        #2 words = n;
        go = 1'b1;
        repeat (4) @(posedge ref_clk);
        issue(4'h8, r);
        check(r, 1'b0);
    endtask
    ////////////////////////////////////////
    task automatic t_reset();
        repeat (3) @(posedge ref_clk);
        #2;
        check(pins.dmack_n, 1'b1); // no burst
        check(pins.dd_oe_n, 1'b1); // bus released
        check(stat.pio_allow, 1'b1); // access open
        reset_n = 1'b1;
    endtask
    task automatic t_dev_term();
        open_burst(8'h05);
        wait_idle();
        check(stat.dev_term, 1'b1); // drive ended
        check(crc_bad, 1'b0); // value matches
        check(stat.pio_allow, 1'b1); // access reopened
        check_word(seen_count, 16'h0005); // dummy edge not counted
        check_word(seen_data, 16'h04fb); // last word intact
    endtask
    task automatic t_host_term();
        logic r;
        open_burst(8'h00);
        repeat (2) @(posedge ref_clk);
        issue(4'h1, r);
        check(r, 1'b1); // stop before a word
        issue(4'h2, r);
        check(r, 1'b1); // resume unpaused
        repeat (20) @(posedge ref_clk);
        issue(4'h4, r);
        check(pins.hdmardy_n, 1'b1); // ready negated
        issue(4'h4, r);
        check(r, 1'b1); // second pause
        repeat (10) @(posedge ref_clk);
        issue(4'h2, r);
        check(pins.hdmardy_n, 1'b0); // ready asserted
        repeat (10) @(posedge ref_clk);
        issue(4'h1, r);
        check(pins.stop, 1'b0); // stop waits
        wait_idle();
        check(stat.dev_term, 1'b0); // host ended
        check(crc_bad, 1'b0); // extra words taken
    endtask
    task automatic t_dev_pause();
        open_burst(8'h08);
        repeat (12) @(posedge ref_clk);
        #2 hold = 1'b1;
        repeat (40) @(posedge ref_clk);
        check(pins.stop, 1'b0); // no stop in pause
        check(stat.busy, 1'b1); // burst open
        #2 hold = 1'b0;
        wait_idle();
        check(crc_bad, 1'b0); // resumed words
        check_word(seen_count, 16'h0008); // all words taken
        check_word(seen_data, 16'h07f8); // last word intact
    endtask
    ////////////////////////////////////////
    initial
    begin
        cmd = '0;
        go = 1'b0;
        hold = 1'b0;
        words = 8'h00;
        reset_n = 1'b0;
        t_reset();
        t_dev_term();
        t_host_term();
        t_dev_pause();
        summarize();
    end
endmodule
